/* serial_flash_pkg.sv */
package serial_flash_pkg;

  // Array organisation
  localparam int PAGE_BYTES = 256;
  localparam int SECTOR_COUNT = 8;
  localparam int SUBSECTORS_PER_SECTOR = 16;
  localparam int SUBSECTOR_COUNT = 128;
  localparam int PAGES_PER_SECTOR = 256;
  localparam int PAGES_PER_SUBSECTOR = 16;
  localparam int ADDR_W = 19;
  localparam int SECTOR_LSB = 16;
  localparam int SUBSECTOR_LSB = 12;
  localparam int PAGE_LSB = 8;
  localparam int FIFO_DEPTH = 32;
  localparam int BYTE_W = 8;

  // Command bytes
  localparam logic [7:0] WRITE_UNLOCK_CMD = 8'h06;
  localparam logic [7:0] WRITE_LOCK_CMD = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD = 8'h05;
  localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
  localparam logic [7:0] PAGE_REWRITE_CMD = 8'h0A;
  localparam logic [7:0] PAGE_FILL_CMD = 8'h02;
  localparam logic [7:0] PAGE_CLEAR_CMD = 8'hDB;
  localparam logic [7:0] SUBSECTOR_CLEAR_CMD = 8'h20;
  localparam logic [7:0] SECTOR_CLEAR_CMD = 8'hD8;
  localparam logic [7:0] ARRAY_CLEAR_CMD = 8'hC7;
  localparam logic [7:0] SECTOR_LOCK_CMD = 8'hE5;

  // Values after reset, and frame limits
  localparam logic [2:0] PROTECT_RESET = 3'h0;
  localparam logic [7:0] LOCKS_RESET = 8'h00;
  localparam logic [9:0] ADDR_BYTES_END = 10'h004;
  localparam logic [8:0] PAGE_COUNT_MAX = 9'h100;

  typedef enum logic [2:0] {
    OP_PAGE_CLEAR = 3'b000,
    OP_SUBSECTOR_CLEAR = 3'b001,
    OP_SECTOR_CLEAR = 3'b010,
    OP_ARRAY_CLEAR = 3'b011,
    OP_PAGE_FILL = 3'b100
  } opKind_t;

  typedef struct packed {
    opKind_t kind;
    logic [18:0] addr;
    logic [8:0] count;
  } arrayOp_t;

  typedef struct packed {
    logic selectN;
    logic sclk;
    logic serialIn;
    logic writeProtectN;
    logic resetN;
  } pins_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ERASE = 2'b01,
    ST_FILL = 2'b10
  } engine_t;

endpackage

/* page_buffer_ram.sv */
`timescale 1ns/1ps
module page_buffer_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 256,
  parameter int AW = 8
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic we,
  input wire logic [AW-1:0] wAddr,
  input wire logic [WIDTH-1:0] wData,
  input wire logic [AW-1:0] rAddr,
  output logic [WIDTH-1:0] rData
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Storage has no reset; contents are don't-care until written
  always_ff @(posedge sys_clk)
  begin
    if (we)
      mem[wAddr] <= wData;
  end

  // Registered read, one cycle of latency
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      rData <= '0;
    else
      rData <= mem[rAddr];
  end

endmodule // page_buffer_ram

/* stream_fifo.sv */
`timescale 1ns/1ps
module stream_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic flush,
  input wire logic [WIDTH-1:0] inData,
  input wire logic inValid,
  output logic inReady,
  output logic [WIDTH-1:0] outData,
  output logic outValid,
  input wire logic outReady
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wrPtr;
  logic [AW-1:0] rdPtr;
  logic [AW:0] count;
  wire push = inValid & inReady;
  wire pop = outValid & outReady;
  wire load = (count != '0) & (!outValid | pop);

  // Full only when every slot holds a word
  assign inReady = (count != (AW+1)'(DEPTH));

  always_ff @(posedge sys_clk)
  begin
    if (push)
      mem[wrPtr] <= inData;
  end

  // Output word sits in a register in front of the store
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      outValid <= 1'b0;
      outData <= '0;
    end
    else if (flush)
    begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
      outValid <= 1'b0;
    end
    else
    begin
      if (push)
        wrPtr <= wrPtr + 1'b1;
      if (load)
      begin
        outData <= mem[rdPtr];
        rdPtr <= rdPtr + 1'b1;
      end
      if (load)
        outValid <= 1'b1;
      else if (pop)
        outValid <= 1'b0;
      count <= count + (AW+1)'(push) - (AW+1)'(load);
    end
  end

endmodule // stream_fifo

/* serial_flash_pin_interface.sv */
`timescale 1ns/1ps
module serial_flash_pin_interface #(
  parameter int FIFO_WORDS = serial_flash_pkg::FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic selectN,
  input wire logic sclk,
  input wire logic serialIn,
  input wire logic writeProtectN,
  input wire logic resetPinN,
  output logic serialOut,
  output logic serialOutEn,
  output logic powerActive,
  output logic opValid,
  output serial_flash_pkg::arrayOp_t op,
  input wire logic opDone,
  output logic opAbort,
  output logic [7:0] dataOut,
  output logic dataOutValid,
  input wire logic dataOutReady
);

  serial_flash_pkg::pins_t pinRaw;
  serial_flash_pkg::pins_t pinMeta;
  serial_flash_pkg::pins_t pinS;
  logic prevSclk;
  logic prevSel;
  logic armed;
  logic [2:0] bitPhase;
  logic [9:0] byteIndex;
  logic [6:0] rxShift;
  logic [7:0] cmd;
  logic [18:0] addr;
  logic [8:0] dataCount;
  logic [7:0] argByte;
  logic [7:0] txShift;
  logic write_enable_latch;
  logic [2:0] protect;
  logic [7:0] locks;
  serial_flash_pkg::engine_t state;
  logic [8:0] sent;
  logic rdPend;
  logic [7:0] memRData;
  logic fifoInReady;
  logic cmdWasRewrite;

  // Sector guard: top-down region from protect bits, or a sector lock
  function automatic logic sectorGuarded(input logic [2:0] bp, input logic [7:0] lk,
                                         input logic [2:0] sec);
    logic [3:0] top;
    top = 4'h0;
    if (bp >= 3'h4)
      top = 4'h8;
    else if (bp != 3'h0)
      top = 4'h1 << (bp - 3'h1);
    return lk[sec] | ({1'b0, sec} >= (4'h8 - top));
  endfunction

  function automatic logic isFillCmd(input logic [7:0] c);
    return (c == serial_flash_pkg::PAGE_REWRITE_CMD) | (c == serial_flash_pkg::PAGE_FILL_CMD);
  endfunction

  // All pins come from the master's domain
  assign pinRaw = '{selectN: selectN, sclk: sclk, serialIn: serialIn,
                    writeProtectN: writeProtectN, resetN: resetPinN};

  // Two-stage synchroniser; reset to zero so a select held low at start makes no edge
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pinMeta <= '0;
      pinS <= '0;
      prevSclk <= 1'b0;
      prevSel <= 1'b0;
    end
    else
    begin
      pinMeta <= pinRaw;
      pinS <= pinMeta;
      prevSclk <= pinS.sclk; // Edge history of the synchronised clock and select
      prevSel <= pinS.selectN;
    end
  end

  // Edge decode; only the clock edges matter, so idle level low or high both work
  wire sclkRise = pinS.sclk & ~prevSclk;
  wire sclkFall = ~pinS.sclk & prevSclk;
  wire selFall = ~pinS.selectN & prevSel;
  wire selRise = pinS.selectN & ~prevSel;
  wire pinReset = ~pinS.resetN;
  wire selected = ~pinS.selectN & armed & ~pinReset;
  wire busy = (state != serial_flash_pkg::ST_IDLE);
  wire bitIn = sclkRise & selected;
  wire byteDone = bitIn & (bitPhase == 3'h7);
  wire [7:0] newByte = {rxShift, pinS.serialIn};
  wire [7:0] curCmd = (byteIndex == 10'h000) ? newByte : cmd;
  wire statusMode = (cmd == serial_flash_pkg::STATUS_READ_CMD) & (byteIndex != 10'h000);
  wire [7:0] statusByte = {3'h0, protect, write_enable_latch, busy};
  wire [2:0] sector = addr[serial_flash_pkg::SECTOR_LSB +: 3];

  // Page buffer write: low address byte picks the slot, wrapping in the page
  wire dataByte = byteDone & (byteIndex >= serial_flash_pkg::ADDR_BYTES_END);
  wire memWe = dataByte & isFillCmd(cmd) & ~busy;
  wire [7:0] memWAddr = addr[7:0] + dataCount[7:0];

  // Acceptance checks made when select rises
  wire wholeBytes = (bitPhase == 3'h0);
  wire endCmd = selRise & armed & ~pinReset & wholeBytes & (byteIndex != 10'h000) & ~busy;
  wire isWren = (cmd == serial_flash_pkg::WRITE_UNLOCK_CMD) & (byteIndex == 10'h001);
  wire isWrdi = (cmd == serial_flash_pkg::WRITE_LOCK_CMD) & (byteIndex == 10'h001);
  wire isWrsr = (cmd == serial_flash_pkg::STATUS_WRITE_CMD) & (byteIndex == 10'h002);
  wire isLock = (cmd == serial_flash_pkg::SECTOR_LOCK_CMD) & (byteIndex == 10'h005);
  wire isArrayClr = (cmd == serial_flash_pkg::ARRAY_CLEAR_CMD) & (byteIndex == 10'h001);
  wire isAreaClr = ((cmd == serial_flash_pkg::PAGE_CLEAR_CMD)
                   | (cmd == serial_flash_pkg::SUBSECTOR_CLEAR_CMD)
                   | (cmd == serial_flash_pkg::SECTOR_CLEAR_CMD))
                   & (byteIndex == serial_flash_pkg::ADDR_BYTES_END);
  wire isFill = isFillCmd(cmd) & (byteIndex > serial_flash_pkg::ADDR_BYTES_END);
  wire anyGuard = (protect != 3'h0) | (locks != 8'h00);
  wire guardHit = isArrayClr ? anyGuard : sectorGuarded(protect, locks, sector);
  wire startOp = endCmd & write_enable_latch & (isArrayClr | isAreaClr | isFill) & ~guardHit;
  wire regWrite = endCmd & write_enable_latch & (isWrsr | isLock);
  wire fillDone = (sent == op.count) & ~rdPend;
  wire opFinish = busy & opDone & ((state == serial_flash_pkg::ST_ERASE) | fillDone);
  wire lastStep = opFinish & ~((state == serial_flash_pkg::ST_ERASE) & cmdWasRewrite);

  // Commands count only after a select fall seen since reset
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      armed <= 1'b0;
    else if (pinReset)
      armed <= 1'b0;
    else if (selFall)
      armed <= 1'b1;
  end

  // Bit and byte position within the select window
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bitPhase <= 3'h0;
      byteIndex <= 10'h000;
      rxShift <= 7'h00;
    end
    else if (selFall | pinReset)
    begin
      bitPhase <= 3'h0;
      byteIndex <= 10'h000;
    end
    else if (bitIn)
    begin
      rxShift <= newByte[6:0];
      bitPhase <= bitPhase + 3'h1;
      if (byteDone & (byteIndex != 10'h3FF))
        byteIndex <= byteIndex + 10'h001; // Saturates on absurdly long frames
    end
  end

  // Command, address and argument capture
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cmd <= 8'h00;
      addr <= '0;
      argByte <= 8'h00;
      dataCount <= 9'h000;
    end
    else if (selFall | pinReset)
    begin
      cmd <= 8'h00;
      dataCount <= 9'h000;
    end
    else if (byteDone)
    begin
      if (byteIndex == 10'h000)
        cmd <= newByte;
      else if (byteIndex < serial_flash_pkg::ADDR_BYTES_END)
        addr <= {addr[10:0], newByte}; // Upper address bits beyond the array drop off
      if (byteIndex == 10'h001)
        argByte <= newByte;
      else if (dataByte & ~isFillCmd(cmd))
        argByte <= newByte;
      if (memWe & (dataCount != serial_flash_pkg::PAGE_COUNT_MAX))
        dataCount <= dataCount + 9'h001;
    end
  end

  // Write enable latch, protect bits and sector locks
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      write_enable_latch <= 1'b0;
      protect <= serial_flash_pkg::PROTECT_RESET;
      locks <= serial_flash_pkg::LOCKS_RESET;
    end
    else if (pinReset)
    begin
      write_enable_latch <= 1'b0;
      locks <= serial_flash_pkg::LOCKS_RESET;
    end
    else
    begin
      if (endCmd & isWren)
        write_enable_latch <= 1'b1;
      else if ((endCmd & isWrdi) | regWrite | lastStep)
        write_enable_latch <= 1'b0;
      if (regWrite & isWrsr & pinS.writeProtectN)
        protect <= argByte[4:2];
      if (regWrite & isLock)
        locks[sector] <= argByte[0];
    end
  end

  // Internal cycle engine; a rewrite runs a page clear first
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= serial_flash_pkg::ST_IDLE;
      op <= '0;
      opValid <= 1'b0;
      cmdWasRewrite <= 1'b0;
    end
    else if (pinReset)
    begin
      state <= serial_flash_pkg::ST_IDLE;
      opValid <= 1'b0;
    end
    else if (startOp)
    begin
      opValid <= 1'b1;
      op.addr <= addr;
      op.count <= dataCount;
      cmdWasRewrite <= (cmd == serial_flash_pkg::PAGE_REWRITE_CMD);
      state <= serial_flash_pkg::ST_ERASE;
      if (cmd == serial_flash_pkg::PAGE_FILL_CMD)
      begin
        op.kind <= serial_flash_pkg::OP_PAGE_FILL;
        state <= serial_flash_pkg::ST_FILL;
      end
      else if ((cmd == serial_flash_pkg::PAGE_CLEAR_CMD)
               | (cmd == serial_flash_pkg::PAGE_REWRITE_CMD))
        op.kind <= serial_flash_pkg::OP_PAGE_CLEAR;
      else if (cmd == serial_flash_pkg::SUBSECTOR_CLEAR_CMD)
        op.kind <= serial_flash_pkg::OP_SUBSECTOR_CLEAR;
      else if (cmd == serial_flash_pkg::SECTOR_CLEAR_CMD)
        op.kind <= serial_flash_pkg::OP_SECTOR_CLEAR;
      else
        op.kind <= serial_flash_pkg::OP_ARRAY_CLEAR;
    end
    else if (opFinish)
    begin
      if ((state == serial_flash_pkg::ST_ERASE) & cmdWasRewrite)
      begin
        op.kind <= serial_flash_pkg::OP_PAGE_FILL;
        state <= serial_flash_pkg::ST_FILL;
        cmdWasRewrite <= 1'b0;
      end
      else
      begin
        state <= serial_flash_pkg::ST_IDLE;
        opValid <= 1'b0;
      end
    end
  end

  // Abort pulse when the reset pin cuts an internal cycle short
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      opAbort <= 1'b0;
    else
      opAbort <= pinReset & busy;
  end

  // Buffer to FIFO streaming; one read in flight keeps the RAM data stable
  wire issueRead = (state == serial_flash_pkg::ST_FILL) & ~rdPend & (sent != op.count);
  wire pushWord = rdPend & fifoInReady;
  wire [7:0] memRAddr = op.addr[7:0] + sent[7:0];
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sent <= 9'h000;
      rdPend <= 1'b0;
    end
    else if (pinReset | ~busy)
    begin
      sent <= 9'h000;
      rdPend <= 1'b0;
    end
    else if (issueRead)
      rdPend <= 1'b1;
    else if (pushWord)
    begin
      rdPend <= 1'b0;
      sent <= sent + 9'h001;
    end
  end

  // Status shift-out; reloaded at each byte edge so busy stays current
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      txShift <= 8'h00;
      serialOut <= 1'b0;
      serialOutEn <= 1'b0;
    end
    else
    begin
      if (byteDone & (curCmd == serial_flash_pkg::STATUS_READ_CMD))
        txShift <= statusByte;
      else if (sclkFall & selected & statusMode)
      begin
        serialOut <= txShift[7];
        txShift <= {txShift[6:0], txShift[7]};
      end
      serialOutEn <= selected & statusMode;
    end
  end

  // Active while selected or while an internal cycle runs
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      powerActive <= 1'b0;
    else
      powerActive <= ~pinS.selectN | busy;
  end

  page_buffer_ram #(.WIDTH(serial_flash_pkg::BYTE_W), .DEPTH(serial_flash_pkg::PAGE_BYTES),
    .AW(8)) u_page (.sys_clk(sys_clk), .nrst(nrst), .we(memWe), .wAddr(memWAddr),
    .wData(newByte), .rAddr(memRAddr), .rData(memRData));

  stream_fifo #(.WIDTH(serial_flash_pkg::BYTE_W), .DEPTH(FIFO_WORDS),
    .AW($clog2(FIFO_WORDS))) u_fifo (.sys_clk(sys_clk), .nrst(nrst), .flush(pinReset),
    .inData(memRData), .inValid(rdPend), .inReady(fifoInReady), .outData(dataOut),
    .outValid(dataOutValid), .outReady(dataOutReady));

endmodule // serial_flash_pin_interface

/* serial_flash_pin_interface_sva.sv */
`timescale 1ns/1ps
module serial_flash_pin_interface_sva #(
  parameter int FIFO_WORDS = 32
) (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic selectN,
  input wire logic sclk,
  input wire logic serialIn,
  input wire logic writeProtectN,
  input wire logic resetPinN,
  input wire logic serialOut,
  input wire logic serialOutEn,
  input wire logic powerActive,
  input wire logic opValid,
  input wire serial_flash_pkg::arrayOp_t op,
  input wire logic opDone,
  input wire logic opAbort,
  input wire logic [7:0] dataOut,
  input wire logic dataOutValid,
  input wire logic dataOutReady
);
  // One domain, so clock and disable are stated once
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!nrst);
  // Five cycles cover the pin synchroniser plus the output register
  property p_outOffDeselected;
    selectN [*5] |-> !serialOutEn;
  endproperty
  a_outOffDeselected: assert property (p_outOffDeselected)
    else $error("Serial output driven while deselected");
  property p_activeSelected;
    !selectN [*5] |-> powerActive;
  endproperty
  a_activeSelected: assert property (p_activeSelected)
    else $error("Not in active power while selected");
  // Standby only once no array operation is pending
  property p_standbyIdle;
    (selectN && !opValid) [*5] |-> !powerActive;
  endproperty
  a_standbyIdle: assert property (p_standbyIdle)
    else $error("Still in active power while deselected and idle");
  property p_resetPinQuiet;
    !resetPinN [*5] |-> !serialOutEn && !opValid;
  endproperty
  a_resetPinQuiet: assert property (p_resetPinQuiet)
    else $error("Output or operation alive during reset pin");
  property p_abortOnReset;
    $fell(resetPinN) && opValid |-> ##[1:5] opAbort;
  endproperty
  a_abortOnReset: assert property (p_abortOnReset)
    else $error("No abort when reset pin hit a busy operation");
  property p_abortSingle;
    opAbort |=> !opAbort;
  endproperty
  a_abortSingle: assert property (p_abortSingle)
    else $error("Abort pulse longer than one cycle");
  // Output moves only a few cycles after the serial clock went low
  property p_shiftOnFall;
    serialOutEn && $past(serialOutEn) && $changed(serialOut) |-> !$past(sclk, 3);
  endproperty
  a_shiftOnFall: assert property (p_shiftOnFall)
    else $error("Serial output changed away from a clock fall");
  property p_fillCount;
    opValid && op.kind == serial_flash_pkg::OP_PAGE_FILL |-> op.count inside {[9'h001:9'h100]};
  endproperty
  a_fillCount: assert property (p_fillCount)
    else $error("Page fill byte count out of range");
  property p_eraseDone;
    opValid && opDone && op.kind inside {serial_flash_pkg::OP_SUBSECTOR_CLEAR,
      serial_flash_pkg::OP_SECTOR_CLEAR, serial_flash_pkg::OP_ARRAY_CLEAR} |=> !opValid;
  endproperty
  a_eraseDone: assert property (p_eraseDone)
    else $error("Erase request not retired after completion");
  // Held request must not drift while the array side works on it
  property p_opHeld;
    resetPinN [*4] ##0 (opValid && !opDone) |=> opValid && $stable(op);
  endproperty
  a_opHeld: assert property (p_opHeld)
    else $error("Array request changed before completion");
endmodule // serial_flash_pin_interface_sva

/* spi_master_model.sv */
`timescale 1ns/1ps
module spi_master_model (
  output logic selectN,
  output logic sclk,
  output logic serialIn,
  input wire logic serialOut
);
  logic idleHigh;
  logic [7:0] rxByte;
  // Starts selected, so the first frame lacks a select fall
  initial
  begin
    idleHigh = 1'h0;
    selectN = 1'h0;
    sclk = 1'h0;
    serialIn = 1'h0;
    rxByte = 8'h00;
  end
  // Margin around select for the device's pin synchronisers
  task automatic sel(input logic v);
    #100 selectN = v;
    #100;
  endtask
  // Clock parks at the mode 0/0 or 1/1 idle level while deselected
  task automatic park(input logic hi);
    idleHigh = hi;
    sclk = hi;
    #200;
  endtask
  // MSB first, data set while low, read back at the rise
  task automatic xfer(input logic [7:0] tx, input int nbits);
    for (int i = 7; i > 7 - nbits; i--)
    begin
      sclk = 1'h0;
      serialIn = tx[i];
      #62.5 sclk = 1'h1;
      rxByte[i] = serialOut;
      #62.5;
    end
    // Clock stands still between bytes; data line shows a stale-proof level
    sclk = idleHigh;
    serialIn = ~serialIn;
  endtask
endmodule // spi_master_model

/* serial_flash_pin_interface_tb_top.sv */
`timescale 1ns/1ps
module serial_flash_pin_interface_tb_top;
  logic sys_clk;
  logic nrst;
  logic writeProtectN;
  logic resetPinN;
  logic opDone;
  logic dataOutReady;
  logic selectN;
  logic sclk;
  logic serialIn;
  logic serialOut;
  logic serialOutEn;
  logic powerActive;
  logic opValid;
  logic opAbort;
  serial_flash_pkg::arrayOp_t op;
  logic [7:0] dataOut;
  logic dataOutValid;
  logic floatBit = 1'h0;
  logic abortSeen = 1'h0;
  logic soWire;
  logic [7:0] st;
  int bad_count;
  int cmp_count;
  // Released output toggles so a stale level cannot pass for data
  assign soWire = serialOutEn ? serialOut : floatBit;
  spi_master_model m (.selectN(selectN), .sclk(sclk), .serialIn(serialIn), .serialOut(soWire));
  serial_flash_pin_interface DUT (.sys_clk(sys_clk), .nrst(nrst),
    .selectN(selectN), .sclk(sclk), .serialIn(serialIn), .writeProtectN(writeProtectN),
    .resetPinN(resetPinN), .serialOut(serialOut), .serialOutEn(serialOutEn),
    .powerActive(powerActive), .opValid(opValid), .op(op), .opDone(opDone),
    .opAbort(opAbort), .dataOut(dataOut), .dataOutValid(dataOutValid),
    .dataOutReady(dataOutReady));
  // System clock
  initial
  begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Float pattern and sticky abort capture
  always @(posedge sys_clk)
  begin
    floatBit <= ~floatBit;
    if (opAbort === 1'h1)
      abortSeen <= 1'h1;
  end
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Inputs move one nanosecond after the rising edge
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic frame(input logic [7:0] c, input logic [23:0] a, input int na,
                       input logic [7:0] d, input int nd, input int tail);
    m.sel(1'h0);
    m.xfer(c, 8);
    for (int i = 0; i < na; i++)
      m.xfer(a[23 - 8 * i -: 8], 8);
    for (int i = 0; i < nd; i++)
      m.xfer(8'(d + i * 17), 8);
    if (tail > 0)
      m.xfer(8'hFF, tail);
    m.sel(1'h1);
    tick(1);
  endtask
  task automatic write_unlock_cmd();
    frame(serial_flash_pkg::WRITE_UNLOCK_CMD, 24'h000000, 0, 8'h00, 0, 0);
  endtask
  task automatic rdsr();
    m.sel(1'h0);
    m.xfer(serial_flash_pkg::STATUS_READ_CMD, 8);
    m.xfer(8'h00, 8);
    st = m.rxByte;
    check("outEnSelected", 1'h1, serialOutEn);
    check("powerSelected", 1'h1, powerActive);
    m.sel(1'h1);
    check("outEnDeselected", 1'h0, serialOutEn);
    check("powerDeselected", 1'h0, powerActive);
    tick(1);
  endtask
  // Bounded wait for the request line to reach a level
  task automatic wait_op(input logic v);
    int k;
    k = 0;
    while (opValid !== v && k < 300)
    begin
      tick(1);
      k++;
    end
  endtask
  task automatic pulse_done();
    opDone = 1'h1;
    tick(1);
    opDone = 1'h0;
    tick(2);
  endtask
  // Stall long enough for the FIFO to fill and refuse, then drain it dry
  task automatic drain(input logic [7:0] d, input int n);
    int k;
    tick(120);
    dataOutReady = 1'h1;
    for (int i = 0; i < n; i++)
    begin
      k = 0;
      while (dataOutValid !== 1'h1 && k < 50)
      begin
        tick(1);
        k++;
      end
      check("fillByte", 8'(d + i * 17), dataOut);
      tick(1);
    end
    dataOutReady = 1'h0;
    tick(4);
    check("fifoEmpty", 1'h0, dataOutValid);
  endtask
  task automatic t_first_fall();
    write_unlock_cmd();
    rdsr();
    check("welWithoutFall", 1'h0, st[1]);
    write_unlock_cmd();
    rdsr();
    check("welAfterUnlock", 1'h1, st[1]);
    $display("Test first_fall done");
  endtask
  task automatic t_refuse();
    frame(serial_flash_pkg::WRITE_LOCK_CMD, 24'h000000, 0, 8'h00, 0, 0);
    frame(serial_flash_pkg::PAGE_FILL_CMD, 24'h000100, 3, 8'h10, 2, 0);
    tick(30);
    check("fillWithoutUnlock", 1'h0, opValid);
    write_unlock_cmd();
    frame(serial_flash_pkg::PAGE_FILL_CMD, 24'h000100, 3, 8'h10, 2, 3);
    tick(30);
    check("fillOddBits", 1'h0, opValid);
    rdsr();
    check("welKeptOnRefusal", 1'h1, st[1]);
    $display("Test refuse done");
  endtask
  task automatic t_fill();
    write_unlock_cmd();
    frame(serial_flash_pkg::PAGE_FILL_CMD, 24'h0123FE, 3, 8'hA1, 256, 0);
    wait_op(1'h1);
    check("fillKind", serial_flash_pkg::OP_PAGE_FILL, op.kind);
    check("fillAddr", 19'h123FE, op.addr);
    check("fillCount", 9'h100, op.count);
    drain(8'hA1, 256);
    pulse_done();
    check("fillRetired", 1'h0, opValid);
    rdsr();
    check("welAfterFill", 1'h0, st[1]);
    $display("Test fill done");
  endtask
  task automatic t_erase();
    logic [7:0] c [4];
    c = '{serial_flash_pkg::PAGE_CLEAR_CMD, serial_flash_pkg::SUBSECTOR_CLEAR_CMD,
          serial_flash_pkg::SECTOR_CLEAR_CMD, serial_flash_pkg::ARRAY_CLEAR_CMD};
    for (int i = 0; i < 4; i++)
    begin
      // Alternate clock modes between frames
      m.park(i[0]);
      write_unlock_cmd();
      frame(c[i], 24'h07F123, (i == 3) ? 0 : 3, 8'h00, 0, 0);
      wait_op(1'h1);
      check("eraseKind", 3'(i), op.kind);
      if (i < 3)
        check("eraseAddr", 19'h7F123, op.addr);
      pulse_done();
      check("eraseRetired", 1'h0, opValid);
    end
    m.park(1'h0);
    $display("Test erase done");
  endtask
  task automatic t_rewrite();
    write_unlock_cmd();
    frame(serial_flash_pkg::PAGE_REWRITE_CMD, 24'h000200, 3, 8'h5A, 1, 0);
    wait_op(1'h1);
    check("rewriteFirst", serial_flash_pkg::OP_PAGE_CLEAR, op.kind);
    pulse_done();
    check("rewriteStays", 1'h1, opValid);
    check("rewriteSecond", serial_flash_pkg::OP_PAGE_FILL, op.kind);
    check("rewriteCount", 9'h001, op.count);
    drain(8'h5A, 1);
    pulse_done();
    check("rewriteRetired", 1'h0, opValid);
    $display("Test rewrite done");
  endtask
  task automatic t_reset_pin();
    write_unlock_cmd();
    frame(serial_flash_pkg::SECTOR_CLEAR_CMD, 24'h010000, 3, 8'h00, 0, 0);
    wait_op(1'h1);
    resetPinN = 1'h0;
    tick(8);
    check("abortSeen", 1'h1, abortSeen);
    check("opDropped", 1'h0, opValid);
    check("outOffInReset", 1'h0, serialOutEn);
    resetPinN = 1'h1;
    tick(4);
    rdsr();
    check("welAfterReset", 1'h0, st[1]);
    $display("Test reset_pin done");
  endtask
  task automatic t_protect();
    writeProtectN = 1'h0;
    write_unlock_cmd();
    frame(serial_flash_pkg::STATUS_WRITE_CMD, 24'h000000, 0, 8'h1C, 1, 0);
    rdsr();
    check("bitsFrozen", 3'h0, st[4:2]);
    writeProtectN = 1'h1;
    write_unlock_cmd();
    frame(serial_flash_pkg::STATUS_WRITE_CMD, 24'h000000, 0, 8'h04, 1, 0);
    rdsr();
    check("bitsWritten", 3'h1, st[4:2]);
    write_unlock_cmd();
    frame(serial_flash_pkg::SECTOR_CLEAR_CMD, 24'h070000, 3, 8'h00, 0, 0);
    tick(30);
    check("topSectorGuarded", 1'h0, opValid);
    frame(serial_flash_pkg::SECTOR_CLEAR_CMD, 24'h060000, 3, 8'h00, 0, 0);
    wait_op(1'h1);
    check("lowerSectorOpen", 1'h1, opValid);
    pulse_done();
    $display("Test protect done");
  endtask
  // Main sequence
  initial
  begin
    nrst = 1'h0;
    writeProtectN = 1'h1;
    resetPinN = 1'h1;
    opDone = 1'h0;
    dataOutReady = 1'h0;
    bad_count = 0;
    cmp_count = 0;
    repeat (4) @(posedge sys_clk);
    #1 nrst = 1'h1;
    tick(4);
    t_first_fall();
    t_refuse();
    t_fill();
    t_erase();
    t_rewrite();
    t_reset_pin();
    t_protect();
    tally_and_finish();
  end
  // Watchdog: the sequence needs well under half of this span
  initial
  begin
    #900000;
    bad_count++;
    $display("Watchdog expired");
    tally_and_finish();
  end
endmodule // serial_flash_pin_interface_tb_top
bind serial_flash_pin_interface serial_flash_pin_interface_sva #(.FIFO_WORDS(FIFO_WORDS)) chk (
  .sys_clk(sys_clk), .nrst(nrst), .selectN(selectN), .sclk(sclk), .serialIn(serialIn),
  .writeProtectN(writeProtectN), .resetPinN(resetPinN), .serialOut(serialOut),
  .serialOutEn(serialOutEn), .powerActive(powerActive), .opValid(opValid), .op(op),
  .opDone(opDone), .opAbort(opAbort), .dataOut(dataOut), .dataOutValid(dataOutValid),
  .dataOutReady(dataOutReady));
